// ===== core/charger_regs.sv
/*
  Host register bank of a single-cell charger, serial target with burst
  access, latched fault/status, default/host mode via host_watchdog.
  Assumes scl/sda inputs already synchronous to ref_clk; open-drain sda.
*/
`timescale 1ns/1ps
`default_nettype none
module charger_regs
#(
  parameter int unsigned TICK      = charger_pkg::TICK_CYCLES,
  parameter logic [7:0]  PART_INFO = 8'h5a  // arbitrary value
)
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [7:0]        status0_in,
  input  wire logic [7:0]        fault_in,
  input  wire logic [7:0]        status2_in,
  output charger_pkg::cfg_t      cfg_out,
  output logic                   host_timeout,
  output logic                   charge_allowed
);
  import charger_pkg::*;

  typedef struct packed {
    state_t     st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rw;
    logic       oe;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] flt;
    logic [2:0] st2;
    cfg_t       cfg;
    logic       wr_p;
    logic       rf_p;
  } core_t;

  core_t      cs_ff;
  core_t      nxt_cs;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       ld;
  logic [7:0] rdv;
  logic [7:0] flt_live;
  logic [3:0] slot;
  logic       wrable;

  wd_if wd ();

  host_watchdog #(.TICK(TICK)) u_wdog
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wd      (wd.tmr)
  );

  //////////////////////////////////////////////////////////////////////
  // bus event detection and read mux
  always_comb
  begin
    rise  = scl_in & ~cs_ff.scl_q;
    fall  = ~scl_in & cs_ff.scl_q;
    start = cs_ff.scl_q & scl_in & cs_ff.sda_q & ~sda_in;
    stop  = cs_ff.scl_q & scl_in & ~cs_ff.sda_q & sda_in;
    flt_live = fault_in;
    flt_live[FLAG_BIT] = wd.default_mode;
    slot   = (cs_ff.ptr == REG_CTRL4) ? CTRL4_SLOT : cs_ff.ptr[3:0];
    wrable = (cs_ff.ptr <= REG_CTRL3) || (cs_ff.ptr == REG_CTRL4);
    if (wrable)
      rdv = cs_ff.cfg[slot];
    else if (cs_ff.ptr == REG_STATUS0)
      rdv = status0_in;
    else if (cs_ff.ptr == REG_FAULT)
      rdv = cs_ff.flt;
    else if (cs_ff.ptr == REG_STATUS2)
      rdv = (status2_in & ~ST2_LATCH) | {1'b0, cs_ff.st2, 4'h0};
    else if (cs_ff.ptr == REG_PARTINFO)
      rdv = PART_INFO;
    else
      rdv = BEYOND_VAL;
  end

  //////////////////////////////////////////////////////////////////////
  // serial target state machine
  always_comb
  begin
    nxt_cs = cs_ff;
    ld = 1'b0;
    nxt_cs.wr_p  = 1'b0;
    nxt_cs.rf_p  = 1'b0;
    nxt_cs.scl_q = scl_in;
    nxt_cs.sda_q = sda_in;
    // sticky capture, a new event is never lost to a read
    nxt_cs.flt = cs_ff.flt | flt_live;
    nxt_cs.st2 = cs_ff.st2 | status2_in[6:4];
    if (wd.expired)
      nxt_cs.cfg = CFG_RST;
    if (start)
    begin
      nxt_cs.st   = ST_ADDR;
      nxt_cs.bits = 4'h0;
      nxt_cs.oe   = 1'b0;
    end
    else if (stop)
    begin
      nxt_cs.st = ST_IDLE;
      nxt_cs.oe = 1'b0;
    end
    else
    begin
      case (cs_ff.st)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (rise && cs_ff.bits != BYTE_BITS)
          begin
            nxt_cs.sh   = {cs_ff.sh[6:0], sda_in};
            nxt_cs.bits = cs_ff.bits + 4'h1;
          end
          else if (fall && cs_ff.bits == BYTE_BITS)
          begin
            nxt_cs.st = ST_IDLE;
            if (cs_ff.st == ST_ADDR)
            begin
              if (cs_ff.sh[7:1] == DEV_ADDR)
              begin
                nxt_cs.oe = 1'b1;
                nxt_cs.rw = cs_ff.sh[0];
                nxt_cs.st = ST_ADDR_ACK;
              end
            end
            else if (cs_ff.st == ST_REG)
            begin
              if (cs_ff.sh <= LAST_REG)
              begin
                nxt_cs.oe  = 1'b1;
                nxt_cs.ptr = cs_ff.sh;
                nxt_cs.st  = ST_REG_ACK;
              end
            end
            else if (cs_ff.ptr <= LAST_REG)
            begin
              nxt_cs.oe   = 1'b1;
              nxt_cs.st   = ST_WDATA_ACK;
              nxt_cs.wr_p = 1'b1;
              nxt_cs.ptr  = cs_ff.ptr + 8'h1;
              if (wrable)
                nxt_cs.cfg[slot] = cs_ff.sh;
              if (cs_ff.ptr == REG_CTRL0)
              begin
                // refresh bit self-clears
                nxt_cs.rf_p = cs_ff.sh[REFRESH_BIT];
                nxt_cs.cfg[slot][REFRESH_BIT] = 1'b0;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK:
        begin
          if (fall)
          begin
            nxt_cs.oe   = 1'b0;
            nxt_cs.bits = 4'h0;
            if (cs_ff.st == ST_ADDR_ACK && cs_ff.rw)
              ld = 1'b1;
            else if (cs_ff.st == ST_ADDR_ACK)
              nxt_cs.st = ST_REG;
            else
              nxt_cs.st = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (fall && cs_ff.bits == LAST_BIT)
          begin
            nxt_cs.oe  = 1'b0;
            nxt_cs.st  = ST_RDATA_ACK;
            nxt_cs.ptr = cs_ff.ptr + 8'h1;
          end
          else if (fall)
          begin
            nxt_cs.bits = cs_ff.bits + 4'h1;
            nxt_cs.sh   = {cs_ff.sh[6:0], 1'b0};
            nxt_cs.oe   = ~cs_ff.sh[6];
          end
        end
        ST_RDATA_ACK:
        begin
          if (rise && sda_in)
            nxt_cs.st = ST_IDLE;
          else if (fall)
            ld = 1'b1;
        end
        default:
          nxt_cs.st = ST_IDLE;
      endcase
    end
    if (ld)
    begin
      nxt_cs.st   = ST_RDATA;
      nxt_cs.bits = 4'h0;
      nxt_cs.sh   = rdv;
      nxt_cs.oe   = ~rdv[7];
      // reading reloads the latch with the live state
      if (cs_ff.ptr == REG_FAULT)
        nxt_cs.flt = flt_live;
      if (cs_ff.ptr == REG_STATUS2)
        nxt_cs.st2 = status2_in[6:4];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_ff <= '0;
      cs_ff.scl_q <= 1'b1;
      cs_ff.sda_q <= 1'b1;
      cs_ff.cfg <= CFG_RST;
    end
    else
      cs_ff <= nxt_cs;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign wd.host_write   = cs_ff.wr_p;
  assign wd.refresh      = cs_ff.rf_p;
  assign wd.wd_sel       = cs_ff.cfg[REG_CTRL1[3:0]][WD_HI:WD_LO];
  assign sda_out         = 1'b0;
  assign sda_oe          = cs_ff.oe;
  assign cfg_out         = cs_ff.cfg;
  assign host_timeout    = wd.default_mode;
  // converter keeps running; only charging is gated
  assign charge_allowed  = ~(wd.default_mode & wd.safety_done);

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ptr_step_a: assert property (cs_ff.st == ST_WDATA && nxt_cs.st == ST_WDATA_ACK |=> cs_ff.ptr == $past(cs_ff.ptr) + 8'h1)
    else $error("pointer did not step after write byte");
  fault_hold_a: assert property (!ld |=> (cs_ff.flt & $past(flt_live)) == $past(flt_live))
    else $error("fault event not latched");
  read_reload_a: assert property (ld && cs_ff.ptr == REG_FAULT |=> cs_ff.sh == $past(cs_ff.flt) && cs_ff.flt[6:0] == $past(flt_live[6:0]))
    else $error("fault read did not report then reload");
  bad_reg_nack_a: assert property (cs_ff.st == ST_REG && fall && !start && !stop && cs_ff.bits == BYTE_BITS && cs_ff.sh > LAST_REG |=> cs_ff.st == ST_IDLE && !sda_oe)
    else $error("undefined register acknowledged");
  beyond_ff_a: assert property (ld && cs_ff.ptr > LAST_REG |=> cs_ff.sh == BEYOND_VAL)
    else $error("read beyond last register not all ones");
  addr_ack_a: assert property (cs_ff.st == ST_ADDR && nxt_cs.st == ST_ADDR_ACK |-> cs_ff.sh[7:1] == DEV_ADDR)
    else $error("acknowledged a foreign address");
  expire_restore_a: assert property (wd.expired && !cs_ff.wr_p ##1 !(cs_ff.wr_p) |-> cfg_out == CFG_RST || $past(cs_ff.st) == ST_WDATA)
    else $error("defaults not restored on expiry");
  stop_charge_a: assert property (wd.default_mode && wd.safety_done |-> !charge_allowed)
    else $error("charging continued after safety timer");
  flag_mode_a: assert property ($fell(wd.default_mode) |-> !host_timeout && $past(cs_ff.wr_p))
    else $error("mode change without host write");

  burst_write_c: cover property (cs_ff.st == ST_WDATA_ACK ##[1:200] cs_ff.st == ST_WDATA_ACK);
  burst_read_c: cover property (cs_ff.st == ST_RDATA_ACK ##[1:200] cs_ff.st == ST_RDATA_ACK);
  bad_reg_c: cover property (cs_ff.st == ST_REG ##1 cs_ff.st == ST_IDLE);
  fault_twice_c: cover property (ld && cs_ff.ptr == REG_FAULT ##[1:400] ld && cs_ff.ptr == REG_FAULT);
endmodule
`default_nettype wire

// ===== core/charger_pkg.sv
/*
  Shared constants and types for the charger host register bank:
  register offsets, reset values, field positions, timing and states.
  Assumes a single 125 MHz clock domain.
*/
package charger_pkg;

  // serial target identity
  localparam logic [6:0] DEV_ADDR = 7'h6a;

  // register offsets
  localparam logic [7:0] REG_CTRL0    = 8'h01;
  localparam logic [7:0] REG_CTRL1    = 8'h05;
  localparam logic [7:0] REG_CTRL3    = 8'h07;
  localparam logic [7:0] REG_STATUS0  = 8'h08;
  localparam logic [7:0] REG_FAULT    = 8'h09;
  localparam logic [7:0] REG_STATUS2  = 8'h0a;
  localparam logic [7:0] REG_PARTINFO = 8'h0b;
  localparam logic [7:0] REG_CTRL4    = 8'h0c;
  localparam logic [7:0] LAST_REG     = 8'h0c;
  localparam logic [7:0] BEYOND_VAL   = 8'hff;
  localparam logic [3:0] CTRL4_SLOT   = 4'h8;

  // writable registers, slot 8 holds charger_control_four
  typedef logic [8:0][7:0] cfg_t;
  localparam cfg_t CFG_RST = {8'h75, 8'h4c, 8'he6, 8'h9e, 8'h40,
                              8'h12, 8'h91, 8'h1a, 8'h17};

  // field positions
  localparam int REFRESH_BIT = 6;
  localparam int WD_HI       = 5;
  localparam int WD_LO       = 4;
  localparam int FLAG_BIT    = 7;
  localparam logic [7:0] ST2_LATCH = 8'h70;

  // watchdog timeout field codes and limits in seconds
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [1:0] WD_SEL1 = 2'h1;
  localparam logic [1:0] WD_SEL2 = 2'h2;
  localparam logic [7:0] WD_LIM1 = 8'h28;
  localparam logic [7:0] WD_LIM2 = 8'h50;
  localparam logic [7:0] WD_LIM3 = 8'ha0;

  // timing
  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned TICK_S       = 1;
  localparam int unsigned TICK_CYCLES  = TICK_S * CLK_HZ;
  localparam int unsigned SAFETY_HOURS = 10;
  localparam int unsigned SEC_PER_HOUR = 3600;
  localparam logic [15:0] SAFETY_S     = 16'(SAFETY_HOURS * SEC_PER_HOUR);
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [3:0]  LAST_BIT     = 4'h7;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_REG      = 4'b0011,
    ST_REG_ACK  = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_WDATA_ACK= 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RDATA_ACK= 4'b1000
  } state_t;

endpackage

// ===== core/wd_if.sv
/*
  Carrier between the register bank and the host watchdog.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface wd_if;
  logic       host_write;
  logic       refresh;
  logic [1:0] wd_sel;
  logic       expired;
  logic       default_mode;
  logic       safety_done;

  modport regs (output host_write, refresh, wd_sel,
                input  expired, default_mode, safety_done);
  modport tmr  (input  host_write, refresh, wd_sel,
                output expired, default_mode, safety_done);
endinterface
`default_nettype wire

// ===== core/host_watchdog.sv
/*
  Host watchdog and default-mode safety timer.
  Assumes host_write and refresh are one-cycle pulses from the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
module host_watchdog
#(
  parameter int unsigned TICK = charger_pkg::TICK_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  wd_if.tmr        wd
);
  import charger_pkg::*;

  typedef struct packed {
    logic        dflt;
    logic        expired;
    logic        done;
    logic [26:0] tick;
    logic [7:0]  wd_s;
    logic [15:0] safe_s;
  } wdog_t;

  wdog_t      wd_ff;
  wdog_t      nxt_wd;
  logic       tick_hit;
  logic [7:0] lim;

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_wd = wd_ff;
    nxt_wd.expired = 1'b0;
    tick_hit = (wd_ff.tick == 27'(TICK - 1));
    nxt_wd.tick = tick_hit ? 27'h0 : wd_ff.tick + 27'h1;
    case (wd.wd_sel)
      WD_SEL1: lim = WD_LIM1;
      WD_SEL2: lim = WD_LIM2;
      default: lim = WD_LIM3;
    endcase
    if (wd.host_write && wd_ff.dflt)
    begin
      nxt_wd.dflt = 1'b0;
      nxt_wd.wd_s = 8'h0;
    end
    else if (wd.refresh)
      nxt_wd.wd_s = 8'h0;
    else if (!wd_ff.dflt && wd.wd_sel != WD_OFF && tick_hit)
    begin
      if (wd_ff.wd_s + 8'h1 >= lim)
      begin
        nxt_wd.dflt = 1'b1;
        nxt_wd.expired = 1'b1;
        nxt_wd.wd_s = 8'h0;
      end
      else
        nxt_wd.wd_s = wd_ff.wd_s + 8'h1;
    end
    // safety timer only runs in default mode
    if (!wd_ff.dflt)
    begin
      nxt_wd.safe_s = 16'h0;
      nxt_wd.done = 1'b0;
    end
    else if (tick_hit && !wd_ff.done)
    begin
      nxt_wd.safe_s = wd_ff.safe_s + 16'h1;
      if (wd_ff.safe_s + 16'h1 == SAFETY_S)
        nxt_wd.done = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wd_ff <= '0;
      wd_ff.dflt <= 1'b1;
    end
    else
      wd_ff <= nxt_wd;
  end

  assign wd.expired      = wd_ff.expired;
  assign wd.default_mode = wd_ff.dflt;
  assign wd.safety_done  = wd_ff.done;

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  write_leaves_default_a: assert property (wd.host_write && wd.default_mode |=> !wd.default_mode)
    else $error("write did not leave default mode");
  expire_sets_mode_a: assert property (wd.expired |-> wd.default_mode && !$past(wd.default_mode))
    else $error("expiry without entering default mode");
  wd_disabled_a: assert property ($past(wd.wd_sel) == WD_OFF |-> !wd.expired)
    else $error("watchdog expired while disabled");
  reset_default_a: assert property ($past(sys_rst) |-> wd.default_mode)
    else $error("not in default mode after reset");
  safety_count_a: assert property ($rose(wd.safety_done) |-> $past(wd_ff.safe_s) == SAFETY_S - 16'h1)
    else $error("safety timer ended at wrong count");
  expiry_c: cover property (wd.expired);
endmodule
`default_nettype wire

// ===== sim/i2c_host.sv
/*
  Bus host model: drives scl, pulls sda low, sends and takes bytes MSB first.
  Assumes the bench resolves sda with a pull-up; everything runs on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_host
#(
  parameter int PH = 2
)
(
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // changes land 1 ns after an edge
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // also a repeated start
  task automatic start();
    sda_low = 1'b0;
    hold(PH);
    scl = 1'b1;
    hold(PH);
    sda_low = 1'b1;
    hold(PH);
    scl = 1'b0;
    hold(PH);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hold(PH);
    scl = 1'b1;
    hold(PH);
    sda_low = 1'b0;
    hold(PH);
  endtask

  // sda only moves while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    hold(PH);
    scl = 1'b1;
    hold(PH);
    r = sda_line;
    scl = 1'b0;
    hold(PH);
  endtask

  // eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, nak);
  endtask
endmodule
`default_nettype wire

// ===== sim/charger_host_register_watchdog_tb.sv
/*
  Self-checking bench for charger_regs with the bus host model.
  Assumes TICK shortened to 2 cycles so the ten-hour timer fits the run.
*/
`timescale 1ns/1ps
`default_nettype none
module charger_host_register_watchdog_tb;
  import charger_pkg::*;
  localparam logic [7:0]  PART_V = 8'h3c;  // arbitrary value
  localparam int unsigned LIMIT  = 80000;
  logic       ref_clk = 1'b0;
  logic       sys_rst;
  logic [7:0] fault_in;
  logic [7:0] status2_in;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;
  logic       host_timeout;
  logic       charge_allowed;
  cfg_t       cfg_out;
  int         bad_count = 0;
  int         n_checks  = 0;
  int         cyc       = 0;
  wire logic  sda_line  = ~(sda_low | sda_oe);

  always #4 ref_clk = ~ref_clk;

  charger_regs #(.TICK(2), .PART_INFO(PART_V)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .status0_in(8'h33), .fault_in(fault_in), .status2_in(status2_in), .cfg_out(cfg_out),
    .host_timeout(host_timeout), .charge_allowed(charge_allowed));

  i2c_host HOST (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic send(input logic [7:0] b, output logic nak);
    logic [7:0] junk;
    HOST.xfer(b, 1'b1, junk, nak);
  endtask

  task automatic wr(input logic [7:0] rg, input logic [7:0] d[$]);
    logic nak;
    HOST.start();
    send({DEV_ADDR, 1'b0}, nak);
    chk(8'(nak), 8'h00, "address ack");
    send(rg, nak);
    chk(8'(nak), 8'h00, "register ack");
    foreach (d[i])
    begin
      send(d[i], nak);
      chk(8'(nak), 8'h00, "data ack");
    end
    HOST.stop();
  endtask

  task automatic rd(input logic [7:0] rg, input int n, output logic [7:0] q[$]);
    logic       nak;
    logic [7:0] b;
    q = {};
    HOST.start();
    send({DEV_ADDR, 1'b0}, nak);
    send(rg, nak);
    HOST.start();
    send({DEV_ADDR, 1'b1}, nak);
    chk(8'(nak), 8'h00, "read address ack");
    for (int i = 0; i < n; i++)
    begin
      HOST.xfer(8'hff, i == n - 1, b, nak);
      q.push_back(b);
    end
    HOST.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] q[$];
    logic [7:0] e;
    chk(8'(host_timeout), 8'h01, "flag after reset");
    chk(8'(charge_allowed), 8'h01, "autonomous charge");
    chk(8'(sda_out), 8'h00, "open drain data low");
    rd(8'h00, 13, q);
    for (int i = 0; i < 13; i++)
    begin
      case (i)
        8: e = 8'h33;
        9: e = 8'h80;
        10: e = 8'h81;
        11: e = PART_V;
        12: e = CFG_RST[8];
        default: e = CFG_RST[i];
      endcase
      chk(q[i], e, "reset burst");
    end
    $display("test reset done");
  endtask

  task automatic t_refuse();
    logic [7:0] q[$];
    logic       nak;
    rd(8'h0c, 2, q);
    chk(q[0], 8'h75, "last register");
    chk(q[1], 8'hff, "beyond last");
    HOST.start();
    send({7'h6b, 1'b0}, nak);
    chk(8'(nak), 8'h01, "foreign address");
    HOST.stop();
    HOST.start();
    send({DEV_ADDR, 1'b0}, nak);
    send(8'h0d, nak);
    chk(8'(nak), 8'h01, "undefined register");
    HOST.stop();
    rd(8'h00, 1, q);
    chk(q[0], 8'h17, "idle after refusal");
    chk(8'(host_timeout), 8'h01, "no write, default");
    $display("test refuse done");
  endtask

  task automatic t_safety();
    wait (cyc >= 71800);
    wait_cyc(1);
    chk(8'(charge_allowed), 8'h01, "before ten hours");
    wait (cyc >= 72300);
    wait_cyc(1);
    chk(8'(charge_allowed), 8'h00, "safety expired");
    $display("test safety done");
  endtask

  task automatic t_host();
    wr(8'h05, {8'h8e, 8'he6, 8'h4c});
    chk(8'(host_timeout), 8'h00, "host mode");
    chk(8'(charge_allowed), 8'h01, "host mode charge");
    chk(cfg_out[5], 8'h8e, "burst write 5");
    chk(cfg_out[6], 8'he6, "burst write 6");
    chk(cfg_out[7], 8'h4c, "burst write 7");
    wait_cyc(800);
    chk(8'(host_timeout), 8'h00, "watchdog off");
    $display("test host done");
  endtask

  task automatic t_refresh();
    wr(8'h05, {8'hbe});
    wr(8'h01, {8'h5a});
    chk(cfg_out[1], 8'h1a, "refresh bit clears");
    wait_cyc(200);
    chk(8'(host_timeout), 8'h00, "refreshed");
    wait_cyc(300);
    chk(8'(host_timeout), 8'h01, "watchdog expired");
    for (int s = 0; s < 9; s++)
      chk(cfg_out[s], CFG_RST[s], "defaults restored");
    $display("test refresh done");
  endtask

  task automatic t_latch();
    logic [7:0] q[$];
    fault_in = 8'h01;
    status2_in = 8'ha1;
    wait_cyc(4);
    fault_in = 8'h00;
    status2_in = 8'h81;
    rd(8'h09, 2, q);
    chk(q[0], 8'h81, "fault reported");
    chk(q[1], 8'ha1, "status change kept");
    rd(8'h09, 2, q);
    chk(q[0], 8'h80, "fault recovered");
    chk(q[1], 8'h81, "status recovered");
    $display("test latch done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    fault_in = 8'h00;
    status2_in = 8'h81;
    wait_cyc(2);
    sys_rst = 1'b0;
    wait_cyc(2);
    t_reset();
    t_refuse();
    t_safety();
    t_host();
    t_refresh();
    t_latch();
    give_verdict();
  end
endmodule
`default_nettype wire
